// file: hdl/dcdma_pkg.sv
// constants and types for the dual cascaded dma controller
package dcdma_pkg;
  // -----------------------------------------------------------------
  // register map (index within one controller)
  // -----------------------------------------------------------------
  localparam logic [3:0] C1_HI    = 4'h0;
  localparam logic [2:0] C2_HI    = 3'h6;
  localparam logic [3:0] IX_STAT  = 4'h8;
  localparam logic [3:0] IX_REQ   = 4'h9;
  localparam logic [3:0] IX_SMASK = 4'ha;
  localparam logic [3:0] IX_MODE  = 4'hb;
  localparam logic [3:0] IX_CPTR  = 4'hc;
  localparam logic [3:0] IX_MCLR  = 4'hd;
  localparam logic [3:0] IX_CMASK = 4'he;
  localparam logic [3:0] IX_AMASK = 4'hf;
  // -----------------------------------------------------------------
  // fields and reset values
  // -----------------------------------------------------------------
  localparam int CMD_DIS = 2;
  localparam int CMD_XWZ = 3;
  localparam int CMD_ROT = 4;
  localparam int CMD_XW  = 5;
  localparam int MD_AUTO = 2;
  localparam int MD_DEC  = 3;
  localparam logic [7:0]  CMD_RST  = 8'h00;
  localparam logic [3:0]  MASK_RST = 4'hf;
  localparam logic [36:0] SYNC_RST = 37'h1b00000000;
  localparam logic [1:0]  XT_VER   = 2'h0;
  localparam logic [1:0]  XT_WR    = 2'h1;
  localparam logic [1:0]  XT_RD    = 2'h2;
  localparam int FIFO_D = 8;
  localparam int DESC_W = 20;
  typedef enum logic [1:0] {
    MD_DEMAND = 2'h0, MD_SINGLE = 2'h1, MD_BLOCK = 2'h2, MD_CASC = 2'h3
  } dcdma_mode_e;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01, ST_HOLD = 7'h02, ST_ADDR = 7'h04, ST_STR1 = 7'h08,
    ST_STR2 = 7'h10, ST_UPDT = 7'h20, ST_CASC = 7'h40
  } dcdma_state_e;
endpackage

// file: hdl/dcdma_top.sv
// dual cascaded dma controller: descriptor fifo and controller top
// Notes on behaviour
// - two controllers, 8-bit and 16-bit, cascaded via channel 4
// - mode field: demand, single, block, cascade
// - single: one transfer per request, bus released
// - terminal count when count wraps zero to ones
// - block runs until terminal count, bus kept
// - demand runs while request held, resumes later
// - cascade holds bus while requested, counters untouched
// - address outputs float while bus master active
// - read, write and verify strobe selection
// - autoinitialize reloads current from base on terminal count
// - fixed or rotating priority within controller
// - 16-bit controller beats 8-bit controller
// - read two clocks, write one or extended two
// - base and current address, step up or down
// - base and current count, decrement per transfer
// - refresh drives page and counter, counter advances
// - command bits disable, rotate, extended write
// - status holds terminal count and request flags
// - software request select, set, ignores mask
// - per-channel mask, single, clear-all, write-all
// - byte pointer toggles per access, clear write
// - master clear resets registers, sets masks
`timescale 1ns/1ns
module dcdma_fifo #(
  parameter int W = 20,
  parameter int D = 8
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  output wire logic         in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output wire logic         out_valid_o,
  input  wire logic         out_ready_i,
  output wire logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0]   cnt_ff;
  logic          ov_ff;
  logic [W-1:0]  od_ff;
  wire take = in_valid_i & in_ready_o;
  wire load = (cnt_ff != '0) & (~ov_ff | out_ready_i);
  assign in_ready_o  = cnt_ff != (AW+1)'(D);
  assign out_valid_o = ov_ff;
  assign out_data_o  = od_ff;
  always_ff @(posedge clk_i) begin
    if (take) begin
      mem[wp_ff] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff  <= take ? AW'(wp_ff + 1'b1) : wp_ff;
      rp_ff  <= load ? AW'(rp_ff + 1'b1) : rp_ff;
      cnt_ff <= (AW+1)'(cnt_ff + take - load);
    end
  end
  // output stage is a register so the top drives straight from flops
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ov_ff <= 1'b0;
      od_ff <= '0;
    end else if (load) begin
      ov_ff <= 1'b1;
      od_ff <= mem[rp_ff];
    end else if (out_ready_i) begin
      ov_ff <= 1'b0;
    end
  end
endmodule

module dcdma_top
  import dcdma_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  IO_ADDR_I,
  input  wire logic [7:0]  DATA_I,
  output logic      [7:0]  DATA_O,
  output logic             DATA_OE_N_O,
  input  wire logic        IOR_N_I,
  output logic             IOR_N_O,
  output logic             IOR_OE_N_O,
  input  wire logic        IOW_N_I,
  output logic             IOW_N_O,
  output logic             IOW_OE_N_O,
  output logic             MEMR_N_O,
  output logic             MEMW_N_O,
  input  wire logic [7:0]  CHANNEL_REQUEST_I,
  output logic      [2:0]  CHANNEL_ACKNOWLEDGE_O,
  output logic             CHANNEL_ACKNOWLEDGE_EN_N_O,
  output logic             HOLD_REQ_O,
  input  wire logic        HOLD_ACK_I,
  output logic             AEN_O,
  output logic             TERMINAL_COUNT_O,
  input  wire logic        BUS_MASTER_N_I,
  input  wire logic        REFRESH_CYCLE_N_I,
  input  wire logic [7:0]  PAGE_I,
  output logic      [23:0] A_O,
  output logic             A_OE_N_O,
  output wire logic [19:0] XFER_DESC_O,
  output wire logic        XFER_VALID_O,
  input  wire logic        XFER_READY_I
);
  // -----------------------------------------------------------------
  // pin synchroniser
  // -----------------------------------------------------------------
  logic [36:0] s1_ff;
  logic [36:0] s2_ff;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      s1_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
    end else begin
      s1_ff <= {BUS_MASTER_N_I, REFRESH_CYCLE_N_I, HOLD_ACK_I, IOR_N_I, IOW_N_I,
                CHANNEL_REQUEST_I, IO_ADDR_I, DATA_I, PAGE_I};
      s2_ff <= s1_ff;
    end
  end
  wire       mst_n = s2_ff[36];
  wire       rfs_n = s2_ff[35];
  wire       hlda  = s2_ff[34];
  wire       ior_n = s2_ff[33];
  wire       iow_n = s2_ff[32];
  wire [7:0] channel_request   = s2_ff[31:24];
  wire [7:0] adr   = s2_ff[23:16];
  wire [7:0] dat   = s2_ff[15:8];
  wire [7:0] page  = s2_ff[7:0];
  // -----------------------------------------------------------------
  // register decode
  // -----------------------------------------------------------------
  dcdma_state_e st_ff;
  dcdma_state_e nxt_st;
  logic         ior_p_ff;
  logic         iow_p_ff;
  logic         rfs_p_ff;
  logic [8:0]   rcnt_ff;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      ior_p_ff <= 1'b1;
      iow_p_ff <= 1'b1;
      rfs_p_ff <= 1'b1;
    end else begin
      ior_p_ff <= ior_n;
      iow_p_ff <= iow_n;
      rfs_p_ff <= rfs_n;
    end
  end
  // our own strobes come back on the pins, so decode only off-cycle
  wire       cpu  = (st_ff == ST_IDLE) | (st_ff == ST_HOLD) | (st_ff == ST_CASC);
  wire       h1   = adr[7:4] == C1_HI;
  wire       h2   = (adr[7:5] == C2_HI) & ~adr[0];
  wire       hit  = (h1 | h2) & cpu;
  wire       csel = h2;
  wire [3:0] idx  = h2 ? adr[4:1] : adr[3:0];
  wire       wr   = iow_p_ff & ~iow_n & hit;
  wire       rd   = ior_p_ff & ~ior_n & hit;
  // -----------------------------------------------------------------
  // controller registers
  // -----------------------------------------------------------------
  logic [7:0]  cmd_w [2];
  logic [3:0]  msk_w [2];
  logic [3:0]  swr_w [2];
  logic [3:0]  tcf_w [2];
  logic        ptr_w [2];
  logic [15:0] ca_w [8];
  logic [15:0] cc_w [8];
  logic [15:0] bc_w [8];
  logic [5:0]  md_w [8];
  logic [7:0]  elig;
  logic [7:0]  tc_ev;
  logic [2:0]  cur_ff;
  logic [2:0]  nxt_ch;
  wire         upd = st_ff == ST_UPDT;
  wire         tc_now = cc_w[cur_ff] == 16'h0000;
  for (genvar g = 0; g < 2; g++) begin : g_ctl
    logic [7:0] cmd_ff;
    logic [3:0] msk_ff;
    logic [3:0] swr_ff;
    logic [3:0] tcf_ff;
    logic       ptr_ff;
    wire        w = wr & (csel == g[0]);
    wire        mclr = w & (idx == IX_MCLR);
    wire [3:0]  tce = tc_ev[g*4 +: 4];
    wire [3:0]  one = 4'h1 << dat[1:0];
    assign cmd_w[g] = cmd_ff;
    assign msk_w[g] = msk_ff;
    assign swr_w[g] = swr_ff;
    assign tcf_w[g] = tcf_ff;
    assign ptr_w[g] = ptr_ff;
    always_ff @(posedge MCLK_I) begin
      if (SRST_I | mclr) begin
        cmd_ff <= CMD_RST;
      end else if (w & (idx == IX_STAT)) begin
        cmd_ff <= dat;
      end
    end
    always_ff @(posedge MCLK_I) begin
      if (SRST_I | mclr) begin
        swr_ff <= 4'h0;
      end else if (w & (idx == IX_REQ)) begin
        swr_ff <= dat[2] ? (swr_ff | one) : (swr_ff & ~one);
      end else begin
        swr_ff <= swr_ff & ~tce;
      end
    end
    always_ff @(posedge MCLK_I) begin
      if (SRST_I | mclr) begin
        msk_ff <= MASK_RST;
      end else if (w & (idx == IX_SMASK)) begin
        msk_ff <= dat[2] ? (msk_ff | one) : (msk_ff & ~one);
      end else if (w & (idx == IX_CMASK)) begin
        msk_ff <= 4'h0;
      end else if (w & (idx == IX_AMASK)) begin
        msk_ff <= dat[3:0];
      end else begin
        for (int k = 0; k < 4; k++) begin
          if (tce[k] & ~md_w[g*4+k][MD_AUTO]) begin
            msk_ff[k] <= 1'b1;
          end
        end
      end
    end
    // a flag raised in the reading cycle survives the clear
    always_ff @(posedge MCLK_I) begin
      if (SRST_I | mclr) begin
        tcf_ff <= 4'h0;
      end else if (rd & (csel == g[0]) & (idx == IX_STAT)) begin
        tcf_ff <= tce;
      end else begin
        tcf_ff <= tcf_ff | tce;
      end
    end
    always_ff @(posedge MCLK_I) begin
      if (SRST_I | mclr | (w & (idx == IX_CPTR))) begin
        ptr_ff <= 1'b0;
      end else if ((w | (rd & (csel == g[0]))) & ~idx[3]) begin
        ptr_ff <= ~ptr_ff;
      end
    end
  end
  // -----------------------------------------------------------------
  // channel registers
  // -----------------------------------------------------------------
  for (genvar i = 0; i < 8; i++) begin : g_ch
    localparam int C = i / 4;
    localparam int N = i % 4;
    logic [15:0] ba_ff;
    logic [15:0] ca_ff;
    logic [15:0] bc_ff;
    logic [15:0] cc_ff;
    logic [5:0]  md_ff;
    logic        dn_ff;
    wire         w  = wr & (csel == C[0]);
    wire         wa = w & (idx == 4'(2*N));
    wire         wc = w & (idx == 4'(2*N+1));
    wire         ui = upd & (cur_ff == 3'(i));
    wire         au = md_ff[MD_AUTO];
    wire [15:0]  na = ptr_w[C] ? {dat, ba_ff[7:0]} : {ba_ff[15:8], dat};
    wire [15:0]  nc = ptr_w[C] ? {dat, bc_ff[7:0]} : {bc_ff[15:8], dat};
    wire         sg = md_ff[5:4] == MD_SINGLE;
    wire         hw = channel_request[i] & ~msk_w[C][N];
    assign ca_w[i]  = ca_ff;
    assign cc_w[i]  = cc_ff;
    assign bc_w[i]  = bc_ff;
    assign md_w[i]  = md_ff;
    assign tc_ev[i] = ui & tc_now;
    // channel 4 only gates the 8-bit controller and never runs itself
    assign elig[i]  = (i != 4) & ~cmd_w[C][CMD_DIS] & (swr_w[C][N] | (hw & ~(sg & dn_ff)));
    always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
        ba_ff <= 16'h0000;
        ca_ff <= 16'h0000;
      end else if (wa) begin
        ba_ff <= na;
        ca_ff <= na;
      end else if (ui) begin
        if (tc_now & au) begin
          ca_ff <= ba_ff;
        end else begin
          ca_ff <= md_ff[MD_DEC] ? 16'(ca_ff - 16'h1) : 16'(ca_ff + 16'h1);
        end
      end
    end
    always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
        bc_ff <= 16'h0000;
        cc_ff <= 16'h0000;
      end else if (wc) begin
        bc_ff <= nc;
        cc_ff <= nc;
      end else if (ui) begin
        cc_ff <= (tc_now & au) ? bc_ff : 16'(cc_ff - 16'h1);
      end
    end
    always_ff @(posedge MCLK_I) begin
      if (SRST_I) begin
        md_ff <= 6'h00;
      end else if (w & (idx == IX_MODE) & (dat[1:0] == 2'(N))) begin
        md_ff <= dat[7:2];
      end
    end
    // peripheral must drop and raise again for the next single transfer
    always_ff @(posedge MCLK_I) begin
      if (SRST_I | ~channel_request[i]) begin
        dn_ff <= 1'b0;
      end else if (ui & sg) begin
        dn_ff <= 1'b1;
      end
    end
  end
  // -----------------------------------------------------------------
  // arbitration
  // -----------------------------------------------------------------
  function automatic logic [2:0] arb(input logic [3:0] r, input logic [1:0] l,
                                     input logic rot);
    logic [1:0] k;
    logic [2:0] res;
    res = 3'h0;
    for (int j = 3; j >= 0; j--) begin
      k = rot ? 2'(l + 2'h1 + 2'(j)) : 2'(j);
      if (r[k]) begin
        res = {1'b1, k};
      end
    end
    return res;
  endfunction
  logic [1:0] last_ff [2];
  wire        gate = ~msk_w[1][0] & ~cmd_w[1][CMD_DIS];
  wire [2:0]  a2 = arb({elig[7:5], 1'b0}, last_ff[1], cmd_w[1][CMD_ROT]);
  wire [2:0]  a1 = arb(elig[3:0] & {4{gate}}, last_ff[0], cmd_w[0][CMD_ROT]);
  wire        win = a2[2] | a1[2];
  wire [2:0]  win_ch = a2[2] ? {1'b1, a2[1:0]} : {1'b0, a1[1:0]};
  wire        go = (st_ff == ST_HOLD) & win & hlda;
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      last_ff[0] <= 2'h3;
      last_ff[1] <= 2'h3;
    end else if (go) begin
      last_ff[win_ch[2]] <= win_ch[1:0];
    end
  end
  // -----------------------------------------------------------------
  // transfer sequencer
  // -----------------------------------------------------------------
  logic        f_rdy;
  wire  [5:0]  md_c = md_w[cur_ff];
  wire         more = (md_c[5:4] == MD_BLOCK) | ((md_c[5:4] == MD_DEMAND) & elig[cur_ff]);
  always_comb begin
    nxt_st = st_ff;
    nxt_ch = go ? win_ch : cur_ff;
    case (st_ff)
      ST_IDLE: begin
        if (win) begin
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (~win) begin
          nxt_st = ST_IDLE;
        end else if (hlda) begin
          nxt_st = (md_w[win_ch][5:4] == MD_CASC) ? ST_CASC : ST_ADDR;
        end
      end
      ST_ADDR: begin
        if (f_rdy) begin
          nxt_st = ST_STR1;
        end
      end
      ST_STR1: nxt_st = ST_STR2;
      ST_STR2: nxt_st = ST_UPDT;
      ST_UPDT: begin
        nxt_st = (more & ~tc_now) ? ST_ADDR : ST_IDLE;
      end
      ST_CASC: begin
        if (~channel_request[cur_ff]) begin
          nxt_st = ST_IDLE;
        end
      end
      default: nxt_st = ST_IDLE;
    endcase
  end
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      st_ff  <= ST_IDLE;
      cur_ff <= 3'h0;
    end else begin
      st_ff  <= nxt_st;
      cur_ff <= nxt_ch;
    end
  end
  // -----------------------------------------------------------------
  // bus outputs, all registered, from the next state or the refresh inputs
  // -----------------------------------------------------------------
  wire       n_xf = (nxt_st == ST_ADDR) | (nxt_st == ST_STR1) | (nxt_st == ST_STR2) |
                    (nxt_st == ST_UPDT);
  wire       n_rd = (nxt_st == ST_STR1) | (nxt_st == ST_STR2);
  wire       xw   = cmd_w[nxt_ch[2]][CMD_XW] & ~cmd_w[nxt_ch[2]][CMD_XWZ];
  wire       n_wr = (nxt_st == ST_STR2) | ((nxt_st == ST_STR1) & xw);
  wire [1:0] xt   = md_w[nxt_ch][1:0];
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      HOLD_REQ_O                 <= 1'b0;
      AEN_O                      <= 1'b0;
      CHANNEL_ACKNOWLEDGE_EN_N_O <= 1'b1;
      CHANNEL_ACKNOWLEDGE_O      <= 3'h0;
      IOR_N_O                    <= 1'b1;
      IOW_N_O                    <= 1'b1;
      MEMR_N_O                   <= 1'b1;
      MEMW_N_O                   <= 1'b1;
      IOR_OE_N_O                 <= 1'b1;
      IOW_OE_N_O                 <= 1'b1;
      TERMINAL_COUNT_O           <= 1'b0;
    end else begin
      HOLD_REQ_O                 <= nxt_st != ST_IDLE;
      AEN_O                      <= n_xf;
      CHANNEL_ACKNOWLEDGE_EN_N_O <= ~(n_xf | (nxt_st == ST_CASC));
      CHANNEL_ACKNOWLEDGE_O      <= nxt_ch;
      IOR_N_O                    <= ~(n_rd & (xt == XT_WR));
      MEMW_N_O                   <= ~(n_wr & (xt == XT_WR));
      MEMR_N_O                   <= ~(n_rd & (xt == XT_RD));
      IOW_N_O                    <= ~(n_wr & (xt == XT_RD));
      // strobes released in cascade, the bus master owns them then
      IOR_OE_N_O                 <= ~n_xf;
      IOW_OE_N_O                 <= ~n_xf;
      TERMINAL_COUNT_O           <= n_rd & (cc_w[nxt_ch] == 16'h0000);
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      rcnt_ff <= 9'h000;
    end else if (~rfs_p_ff & rfs_n) begin
      rcnt_ff <= 9'(rcnt_ff + 9'h1);
    end
  end
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      A_O      <= 24'h000000;
      A_OE_N_O <= 1'b1;
    end else begin
      A_O      <= ~rfs_n ? {page, 7'h00, rcnt_ff} : {page, ca_w[nxt_ch]};
      A_OE_N_O <= ~((n_xf | ~rfs_n) & mst_n);
    end
  end
  // -----------------------------------------------------------------
  // register read port
  // -----------------------------------------------------------------
  wire [2:0]  rch = {csel, idx[2:1]};
  wire [15:0] rw  = idx[0] ? cc_w[rch] : ca_w[rch];
  wire [3:0]  ract = (csel ? channel_request[7:4] : channel_request[3:0]) | swr_w[csel];
  always_ff @(posedge MCLK_I) begin
    if (SRST_I) begin
      DATA_O      <= 8'h00;
      DATA_OE_N_O <= 1'b1;
    end else begin
      DATA_OE_N_O <= ~(~ior_n & hit);
      if (rd) begin
        if (~idx[3]) begin
          DATA_O <= ptr_w[csel] ? rw[15:8] : rw[7:0];
        end else if (idx == IX_STAT) begin
          DATA_O <= {ract, tcf_w[csel]};
        end else begin
          DATA_O <= 8'h00;
        end
      end
    end
  end
  // -----------------------------------------------------------------
  // transfer descriptor fifo, a full fifo stalls the sequencer
  // -----------------------------------------------------------------
  dcdma_fifo #(.W(DESC_W), .D(FIFO_D)) u_fifo (
    .clk_i      (MCLK_I),
    .srst_i     (SRST_I),
    .in_valid_i (st_ff == ST_ADDR),
    .in_ready_o (f_rdy),
    .in_data_i  ({tc_now, cur_ff, ca_w[cur_ff]}),
    .out_valid_o(XFER_VALID_O),
    .out_ready_i(XFER_READY_I),
    .out_data_o (XFER_DESC_O)
  );
  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  wire        rd_on = ~(MEMR_N_O & IOR_N_O);
  wire        wr_on = ~(MEMW_N_O & IOW_N_O);
  wire [15:0] cnt_s = cc_w[cur_ff];
  wire [15:0] bas_s = bc_w[cur_ff];
  chk_rd_width: assert property ($rose(rd_on) |=> rd_on ##1 ~rd_on)
    else $error("read strobe not two clocks");
  chk_wr_norm: assert property ($rose(wr_on) & ~xw |=> ~wr_on)
    else $error("normal write strobe not one clock");
  chk_tc_flag: assert property (upd & tc_now |=> tcf_w[cur_ff[2]][cur_ff[1:0]])
    else $error("terminal count flag missing");
  chk_cnt_dec: assert property (upd & ~tc_now |=> cnt_s == 16'($past(cnt_s) - 16'h1))
    else $error("word count did not decrement");
  chk_auto_load: assert property (upd & tc_now & md_c[MD_AUTO] |=> cnt_s == $past(bas_s))
    else $error("autoinitialize reload missing");
  chk_addr_float: assert property (~mst_n |=> A_OE_N_O)
    else $error("address driven under bus master");
  chk_single_rel: assert property (upd & (md_c[5:4] == MD_SINGLE) |=> st_ff == ST_IDLE)
    else $error("single mode kept the bus");
  chk_block_go: assert property (upd & (md_c[5:4] == MD_BLOCK) & ~tc_now |=> st_ff == ST_ADDR)
    else $error("block mode released early");
  chk_prio_c2: assert property (go & (elig[7:5] != 3'h0) |=> cur_ff[2])
    else $error("8-bit controller won over 16-bit");
  chk_verify_q: assert property ((st_ff == ST_STR1) & (md_c[1:0] == XT_VER) |-> ~rd_on & ~wr_on)
    else $error("verify cycle drove a strobe");
  cov_block_tc: cover property (upd & tc_now & (md_c[5:4] == MD_BLOCK));
  cov_cascade: cover property ((st_ff == ST_CASC) ##1 (st_ff == ST_IDLE));
  cov_fifo_stall: cover property ((st_ff == ST_ADDR) & ~f_rdy);
endmodule

// file: verification/dcdma_partner.sv
// far-side model: cpu bus grant, one peripheral on channel 1, descriptor sink
`timescale 1ns/1ns
module dcdma_partner (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       go_i,
  input  wire logic       hold_req_i,
  input  wire logic       ack_en_n_i,
  input  wire logic [2:0] ack_i,
  output logic            hold_ack_o,
  output logic            req_o,
  output logic            ready_o
);
  // -----------------------------------------------------------------
  // grant lags request by two clocks, sink stalls randomly
  // -----------------------------------------------------------------
  logic [1:0] grant_ff;
  logic [2:0] gap_ff;
  always_ff @(posedge clk_i) begin
    grant_ff <= srst_i ? 2'h0 : {grant_ff[0], hold_req_i};
    ready_o  <= srst_i ? 1'b0 : (($urandom % 3) != 0);
  end
  always_comb hold_ack_o = grant_ff[1] & hold_req_i;
  // low gap after each acknowledge so the next request is a fresh one
  always_ff @(posedge clk_i) begin
    if (srst_i || !go_i) begin
      req_o  <= 1'b0;
      gap_ff <= 3'h0;
    end else if (req_o && !ack_en_n_i && ack_i == 3'h1) begin
      req_o  <= 1'b0;
      gap_ff <= 3'h6;
    end else if (gap_ff != 3'h0) begin
      gap_ff <= gap_ff - 3'h1;
    end else begin
      req_o <= 1'b1;
    end
  end
endmodule

// file: verification/dual_cascaded_dma_control_tb.sv
// self-checking bench for the dual cascaded dma controller
`timescale 1ns/1ns
module dual_cascaded_dma_control_tb;
  import dcdma_pkg::*;
  logic        clk = 0, srst = 1, ior_n = 1, iow_n = 1, go = 0, hack, preq, rdy;
  logic [7:0]  addr = 8'h00, data = 8'h00, rdata;
  logic [15:0] a1, a2, e;
  logic [19:0] desc;
  logic [2:0]  ack;
  logic        ack_en_n, hreq, vld;
  logic        aen, ior_oe_n, iow_oe_n, a_oe_n, tc, mst_n = 1, refresh_cycle_n_n = 1;
  logic [23:0] a_out;
  logic [19:0] q[$];
  int          fail_count = 0, compares = 0;
  always #20 clk = ~clk;
  dcdma_top dut_u (.MCLK_I(clk), .SRST_I(srst), .IO_ADDR_I(addr), .DATA_I(data),
    .DATA_O(rdata), .DATA_OE_N_O(), .IOR_N_I(ior_n), .IOR_N_O(), .IOR_OE_N_O(ior_oe_n),
    .IOW_N_I(iow_n), .IOW_N_O(), .IOW_OE_N_O(iow_oe_n), .MEMR_N_O(), .MEMW_N_O(),
    .CHANNEL_REQUEST_I({6'h00, preq, 1'b0}), .CHANNEL_ACKNOWLEDGE_O(ack),
    .CHANNEL_ACKNOWLEDGE_EN_N_O(ack_en_n), .HOLD_REQ_O(hreq), .HOLD_ACK_I(hack),
    .AEN_O(aen), .TERMINAL_COUNT_O(tc), .BUS_MASTER_N_I(mst_n), .REFRESH_CYCLE_N_I(refresh_cycle_n_n),
    .PAGE_I(8'h3c), .A_O(a_out), .A_OE_N_O(a_oe_n), .XFER_DESC_O(desc), .XFER_VALID_O(vld),
    .XFER_READY_I(rdy));
  dcdma_partner peer_u (.clk_i(clk), .srst_i(srst), .go_i(go), .hold_req_i(hreq),
    .ack_en_n_i(ack_en_n), .ack_i(ack), .hold_ack_o(hack), .req_o(preq), .ready_o(rdy));
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("mismatches %0d, comparisons %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // strobes kept low four clocks (six for reads) and high four so the synchronisers see them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #2 addr = a;
    data = d;
    repeat (3) @(posedge clk);
    #2 iow_n = 0;
    repeat (4) @(posedge clk);
    #2 iow_n = 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #2 addr = a;
    repeat (3) @(posedge clk);
    #2 ior_n = 0;
    repeat (6) @(posedge clk);
    check({12'h000, rdata}, {12'h000, exp});
    #2 ior_n = 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_empty();
    for (int i = 0; i < 3000 && q.size() != 0; i++) @(posedge clk);
    check(20'(q.size()), 20'h0);
  endtask
  // descriptors leave in order; each is compared with the oldest note
  always @(posedge clk) begin
    if (vld === 1'b1 && rdy === 1'b1) begin
      if (q.size() == 0) check(desc, 20'hfffff);
      else check(desc, q.pop_front());
    end
  end
  initial begin
    #800000;
    fail_count++;
    give_verdict();
  end
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  initial begin
    void'($urandom(32'h8dfe));
    a1 = 16'($urandom);
    a2 = 16'($urandom);
    repeat (12) @(posedge clk);
    #2 srst = 0;
    // channel 1 single read, two transfers, count 1
    wr(8'h0c, 8'h00);
    wr(8'h02, a1[7:0]);
    wr(8'h02, a1[15:8]);
    wr(8'h03, 8'h01);
    wr(8'h03, 8'h00);
    wr(8'h0b, 8'h49);
    wr(8'h0e, 8'h00);
    wr(8'hdc, 8'h00);
    q.push_back({1'b0, 3'h1, a1});
    q.push_back({1'b1, 3'h1, a1 + 16'h1});
    #2 go = 1;
    wait_empty();
    repeat (40) @(posedge clk); // masked by terminal count, nothing more runs
    #2 go = 0;
    repeat (10) @(posedge clk);
    rd(8'h08, 8'h02);
    rd(8'h08, 8'h00);
    wr(8'h0c, 8'h00);
    e = a1 + 16'h2;
    rd(8'h02, e[7:0]);
    rd(8'h02, e[15:8]);
    rd(8'h03, 8'hff);
    rd(8'h03, 8'hff);
    // channel 5 block read, address decrement, autoinitialize, started by software
    wr(8'hd8, 8'h00);
    wr(8'hc4, a2[7:0]);
    wr(8'hc4, a2[15:8]);
    wr(8'hc6, 8'h02);
    wr(8'hc6, 8'h00);
    wr(8'hd6, 8'hb9);
    for (int i = 0; i < 3; i++) q.push_back({i == 2, 3'h5, a2 - 16'(i)});
    wr(8'hd2, 8'h05);
    wait_empty();
    rd(8'hd0, 8'h02);
    rd(8'hc4, a2[7:0]);
    rd(8'hc4, a2[15:8]);
    rd(8'hc6, 8'h02);
    // channel 1 as cascade: the master owns the strobes, ours stay released
    wr(8'h0b, 8'hc1);
    wr(8'h0a, 8'h01);
    #2 go = 1;
    for (int i = 0; i < 200 && ack_en_n !== 1'b0; i++) @(negedge clk);
    check(20'({ack_en_n, ack, aen, ior_oe_n, iow_oe_n, a_oe_n, tc}), 20'h0002e);
    @(posedge clk) #2 go = 0;
    repeat (20) @(posedge clk);
    rd(8'h03, 8'hff);
    // refresh shows page and counter; a bus master floats the address
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) #2 refresh_cycle_n_n = 0;
      mst_n = (i != 2);
      repeat (4) @(negedge clk);
      check(20'({a_oe_n, a_out[23:16], a_out[8:0]}), 20'({i == 2, 8'h3c, 9'(i)}));
      @(posedge clk) #2 refresh_cycle_n_n = 1;
      repeat (4) @(posedge clk);
    end
    give_verdict();
  end
endmodule
